// File: pbcd_pkg.sv
// Constants shared by the port B/C/D alternate-function override logic
package pbcd_pkg;
    localparam int PBCD_PORT_W = 8;
    localparam int PBCD_NPIN   = 24;
    localparam int PBCD_B_BASE = 0;
    localparam int PBCD_C_BASE = 8;
    localparam int PBCD_D_BASE = 16;
    // Port B serial pin positions
    localparam int PBCD_SS_BIT   = 0;
    localparam int PBCD_SCK_BIT  = 1;
    localparam int PBCD_MOSI_BIT = 2;
    localparam int PBCD_MISO_BIT = 3;
    // Timer compare outputs sit on port B bits 7..4
    localparam int PBCD_CMP_LO = 4;
    localparam int PBCD_CMP_N  = 4;
    // Port B bit 0 is pin-change source 8, so sources 15..8 map to bits 7..0
    localparam int PBCD_PCINT_BASE = 8;
    // Port D single-function positions
    localparam int PBCD_D_IRQ_BIT = 1;
    localparam int PBCD_D_ICP_BIT = 0;
    // LCD pin-mask thresholds: a port D pair is claimed when the mask exceeds its threshold
    localparam int           PBCD_PM_W    = 3;
    localparam logic [2:0]   PBCD_PM_GT76 = 3'h1;
    localparam logic [2:0]   PBCD_PM_GT54 = 3'h2;
    localparam logic [2:0]   PBCD_PM_GT32 = 3'h3;
    localparam logic [2:0]   PBCD_PM_GT10 = 3'h4;
    localparam int           PBCD_D_SEG_N = 6;
    // Reset values of pad controls: pads undriven, pull-ups and inputs off
    localparam logic [7:0]   PBCD_RST_ZERO = 8'h00;
    localparam logic [7:0]   PBCD_RST_OE_N = 8'hff;
endpackage

// File: pbcd_pin_override.sv
// Single pad override cell: applies alternate-function overrides to one port pin
`timescale 1ns/10ps
module pbcd_pin_override (
    input  wire logic dir_i,
    input  wire logic out_i,
    input  wire logic pud_i,
    input  wire logic sleep_i,
    input  wire logic pullup_override_enable_i,
    input  wire logic puov_i,
    input  wire logic ddoe_i,
    input  wire logic ddov_i,
    input  wire logic port_value_override_enable_i,
    input  wire logic pvov_i,
    input  wire logic digital_input_override_enable_i,
    input  wire logic dieov_i,
    output logic      pullup_o,
    output logic      dir_o,
    output logic      value_o,
    output logic      din_en_o
);
    always_comb begin
        // Ordinary pull-up needs an input pin with its output bit set
        pullup_o = pullup_override_enable_i ? puov_i : (~dir_i & out_i & ~pud_i);
        dir_o    = ddoe_i ? ddov_i : dir_i;
        value_o  = port_value_override_enable_i ? pvov_i : out_i;
        din_en_o = digital_input_override_enable_i ? dieov_i : ~sleep_i;
    end
endmodule // pbcd_pin_override

// File: pbcd_port_mux.sv
// Port B/C/D alternate-function pad override block
`timescale 1ns/10ps
module pbcd_port_mux
    import pbcd_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       reset_n_i,
    input  wire logic [7:0] port_b_dir_i,
    input  wire logic [7:0] port_b_out_i,
    input  wire logic [7:0] port_c_dir_i,
    input  wire logic [7:0] port_c_out_i,
    input  wire logic [7:0] port_d_dir_i,
    input  wire logic [7:0] port_d_out_i,
    input  wire logic [7:0] port_b_pin_i,
    input  wire logic [7:0] port_c_pin_i,
    input  wire logic [7:0] port_d_pin_i,
    input  wire logic       global_pullup_disable_i,
    input  wire logic       input_sleep_disable_i,
    input  wire logic       serial_port_enable_i,
    input  wire logic       serial_master_select_i,
    input  wire logic       spi_master_out_i,
    input  wire logic       spi_slave_out_i,
    input  wire logic       spi_sck_out_i,
    input  wire logic [3:0] timer_compare_enable_i,
    input  wire logic [3:0] timer_compare_value_i,
    input  wire logic       pin_change_group1_enable_i,
    input  wire logic [7:0] pin_change_mask_i,
    input  wire logic       lcd_controller_enable_i,
    input  wire logic [2:0] lcd_pin_mask_i,
    input  wire logic [7:0] lcd_front_plane_5_to_12_i,
    input  wire logic [5:0] lcd_front_plane_15_to_20_i,
    input  wire logic       lcd_front_plane_21_i,
    input  wire logic       lcd_front_plane_22_i,
    input  wire logic       external_irq_zero_enable_i,
    output logic [7:0]      port_b_pullup_o,
    output logic [7:0]      port_b_oe_n_o,
    output logic [7:0]      port_b_value_o,
    output logic [7:0]      port_b_din_en_o,
    output logic [7:0]      port_c_pullup_o,
    output logic [7:0]      port_c_oe_n_o,
    output logic [7:0]      port_c_value_o,
    output logic [7:0]      port_c_din_en_o,
    output logic [7:0]      port_d_pullup_o,
    output logic [7:0]      port_d_oe_n_o,
    output logic [7:0]      port_d_value_o,
    output logic [7:0]      port_d_din_en_o,
    output logic [7:0]      port_c_lcd_sel_o,
    output logic [7:0]      port_c_lcd_seg_o,
    output logic [7:0]      port_d_lcd_sel_o,
    output logic [7:0]      port_d_lcd_seg_o,
    output logic            spi_slave_select_n_o,
    output logic            spi_master_in_o,
    output logic            spi_slave_in_o,
    output logic            spi_sck_in_o,
    output logic [7:0]      pin_change_source_o,
    output logic            external_irq_zero_input_o,
    output logic            timer1_capture_input_o
);
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic pbcd_lcd_claim(input logic en, input logic [2:0] pm, input logic [2:0] thr);
        pbcd_lcd_claim = en & (pm > thr);
    endfunction

    function automatic logic [7:0] pbcd_rev8(input logic [7:0] v);
        for (int k = 0; k < PBCD_PORT_W; k++) begin
            pbcd_rev8[k] = v[PBCD_PORT_W-1-k];
        end
    endfunction

    logic       slave_role;
    logic       master_role;
    logic [7:0] claim_d;
    logic [7:0] b_pullup_override_enable, b_puov, b_port_value_override_enable, b_pvov, b_digital_input_override_enable;
    logic [7:0] d_digital_input_override_enable, d_dieov;
    logic [PBCD_NPIN-1:0] all_dir, all_out, pullup_override_enable, puov, ddoe, ddov, port_value_override_enable, pvov, digital_input_override_enable, dieov;
    logic [PBCD_NPIN-1:0] pullup_c, dir_c, value_c, din_en_c;

    always_comb begin
        slave_role  = serial_port_enable_i & ~serial_master_select_i;
        master_role = serial_port_enable_i & serial_master_select_i;
        claim_d = {{2{pbcd_lcd_claim(lcd_controller_enable_i, lcd_pin_mask_i, PBCD_PM_GT76)}},
                   {2{pbcd_lcd_claim(lcd_controller_enable_i, lcd_pin_mask_i, PBCD_PM_GT54)}},
                   {2{pbcd_lcd_claim(lcd_controller_enable_i, lcd_pin_mask_i, PBCD_PM_GT32)}},
                   {2{pbcd_lcd_claim(lcd_controller_enable_i, lcd_pin_mask_i, PBCD_PM_GT10)}}};
        // Serial pins forced to input by role; pull-up value still from the output bit
        b_pullup_override_enable = PBCD_RST_ZERO;
        b_pullup_override_enable[PBCD_SS_BIT]   = slave_role;
        b_pullup_override_enable[PBCD_SCK_BIT]  = slave_role;
        b_pullup_override_enable[PBCD_MOSI_BIT] = slave_role;
        b_pullup_override_enable[PBCD_MISO_BIT] = master_role;
        b_puov = port_b_out_i & {PBCD_PORT_W{~global_pullup_disable_i}};
        b_port_value_override_enable = PBCD_RST_ZERO;
        b_pvov = PBCD_RST_ZERO;
        b_port_value_override_enable[PBCD_SCK_BIT]  = master_role;
        b_pvov[PBCD_SCK_BIT]  = spi_sck_out_i;
        b_port_value_override_enable[PBCD_MOSI_BIT] = master_role;
        b_pvov[PBCD_MOSI_BIT] = spi_master_out_i;
        b_port_value_override_enable[PBCD_MISO_BIT] = slave_role;
        b_pvov[PBCD_MISO_BIT] = spi_slave_out_i;
        b_port_value_override_enable[PBCD_CMP_LO +: PBCD_CMP_N] = timer_compare_enable_i;
        b_pvov[PBCD_CMP_LO +: PBCD_CMP_N] = timer_compare_value_i;
        b_digital_input_override_enable = pin_change_mask_i & {PBCD_PORT_W{pin_change_group1_enable_i}};
        // Interrupt 0 keeps its input awake in sleep unless the LCD controller is enabled, whatever the pin mask
        d_digital_input_override_enable = claim_d;
        d_dieov = PBCD_RST_ZERO;
        d_digital_input_override_enable[PBCD_D_IRQ_BIT] = lcd_controller_enable_i | external_irq_zero_enable_i;
        d_dieov[PBCD_D_IRQ_BIT] = ~lcd_controller_enable_i & external_irq_zero_enable_i;
        all_dir = {port_d_dir_i, port_c_dir_i, port_b_dir_i};
        all_out = {port_d_out_i, port_c_out_i, port_b_out_i};
        pullup_override_enable  = {claim_d, {PBCD_PORT_W{lcd_controller_enable_i}}, b_pullup_override_enable};
        puov  = {PBCD_RST_ZERO, PBCD_RST_ZERO, b_puov};
        ddoe  = pullup_override_enable;
        ddov  = '0;
        port_value_override_enable  = {PBCD_RST_ZERO, PBCD_RST_ZERO, b_port_value_override_enable};
        pvov  = {PBCD_RST_ZERO, PBCD_RST_ZERO, b_pvov};
        digital_input_override_enable = {d_digital_input_override_enable, {PBCD_PORT_W{lcd_controller_enable_i}}, b_digital_input_override_enable};
        dieov = {d_dieov, PBCD_RST_ZERO, {PBCD_PORT_W{1'b1}}};
    end

    ////////////////////////////////////////////////////////////////////////////
    genvar gi;
    generate
        for (gi = 0; gi < PBCD_NPIN; gi++) begin : g_pin
            pbcd_pin_override u_pin (
                .dir_i    (all_dir[gi]),
                .out_i    (all_out[gi]),
                .pud_i    (global_pullup_disable_i),
                .sleep_i  (input_sleep_disable_i),
                .pullup_override_enable_i   (pullup_override_enable[gi]),
                .puov_i   (puov[gi]),
                .ddoe_i   (ddoe[gi]),
                .ddov_i   (ddov[gi]),
                .port_value_override_enable_i   (port_value_override_enable[gi]),
                .pvov_i   (pvov[gi]),
                .digital_input_override_enable_i  (digital_input_override_enable[gi]),
                .dieov_i  (dieov[gi]),
                .pullup_o (pullup_c[gi]),
                .dir_o    (dir_c[gi]),
                .value_o  (value_c[gi]),
                .din_en_o (din_en_c[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Pad inputs are asynchronous: two flops before anything looks at them
    logic [PBCD_NPIN-1:0] sync1_ff, sync2_ff, nxt_sync1, nxt_sync2, din_gated;
    logic [PBCD_NPIN-1:0] pullup_ff, oe_n_ff, value_ff, din_en_ff;
    logic [PBCD_NPIN-1:0] nxt_pullup, nxt_oe_n, nxt_value, nxt_din_en;
    logic [7:0] c_sel_ff, c_seg_ff, d_sel_ff, d_seg_ff, pcs_ff;
    logic [7:0] nxt_c_sel, nxt_c_seg, nxt_d_sel, nxt_d_seg, nxt_pcs;
    logic [7:0] d_rev;
    logic       ss_n_ff, mi_ff, si_ff, sck_ff, irq0_ff, icp_ff;
    logic       nxt_ss_n, nxt_mi, nxt_si, nxt_sck, nxt_irq0, nxt_icp;

    always_comb begin
        nxt_sync1  = {port_d_pin_i, port_c_pin_i, port_b_pin_i};
        nxt_sync2  = sync1_ff;
        din_gated  = sync2_ff & din_en_c;
        nxt_pullup = pullup_c;
        nxt_oe_n   = ~dir_c;
        nxt_value  = value_c;
        nxt_din_en = din_en_c;
        nxt_c_sel  = {PBCD_PORT_W{lcd_controller_enable_i}};
        nxt_c_seg  = pbcd_rev8(lcd_front_plane_5_to_12_i);
        nxt_d_sel  = claim_d;
        // Padding goes on top so that segment 15 lands on bit 7 after the reversal
        d_rev      = pbcd_rev8({2'h0, lcd_front_plane_15_to_20_i});
        nxt_d_seg  = {d_rev[7:2], lcd_front_plane_21_i, lcd_front_plane_22_i};
        // Not selected unless in slave role with the pin held low or its input gated off in sleep
        nxt_ss_n   = ~slave_role | din_gated[PBCD_B_BASE + PBCD_SS_BIT];
        nxt_mi     = din_gated[PBCD_B_BASE + PBCD_MISO_BIT];
        nxt_si     = din_gated[PBCD_B_BASE + PBCD_MOSI_BIT];
        nxt_sck    = din_gated[PBCD_B_BASE + PBCD_SCK_BIT];
        nxt_pcs    = din_gated[PBCD_B_BASE +: PBCD_PORT_W];
        nxt_irq0   = din_gated[PBCD_D_BASE + PBCD_D_IRQ_BIT];
        nxt_icp    = din_gated[PBCD_D_BASE + PBCD_D_ICP_BIT];
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sync1_ff  <= '0;
            sync2_ff  <= '0;
            pullup_ff <= '0;
            oe_n_ff   <= {PBCD_RST_OE_N, PBCD_RST_OE_N, PBCD_RST_OE_N};
            value_ff  <= '0;
            din_en_ff <= '0;
            c_sel_ff  <= PBCD_RST_ZERO;
            c_seg_ff  <= PBCD_RST_ZERO;
            d_sel_ff  <= PBCD_RST_ZERO;
            d_seg_ff  <= PBCD_RST_ZERO;
            pcs_ff    <= PBCD_RST_ZERO;
            ss_n_ff   <= 1'b1;
            mi_ff     <= 1'b0;
            si_ff     <= 1'b0;
            sck_ff    <= 1'b0;
            irq0_ff   <= 1'b0;
            icp_ff    <= 1'b0;
        end else begin
            sync1_ff  <= nxt_sync1;
            sync2_ff  <= nxt_sync2;
            pullup_ff <= nxt_pullup;
            oe_n_ff   <= nxt_oe_n;
            value_ff  <= nxt_value;
            din_en_ff <= nxt_din_en;
            c_sel_ff  <= nxt_c_sel;
            c_seg_ff  <= nxt_c_seg;
            d_sel_ff  <= nxt_d_sel;
            d_seg_ff  <= nxt_d_seg;
            pcs_ff    <= nxt_pcs;
            ss_n_ff   <= nxt_ss_n;
            mi_ff     <= nxt_mi;
            si_ff     <= nxt_si;
            sck_ff    <= nxt_sck;
            irq0_ff   <= nxt_irq0;
            icp_ff    <= nxt_icp;
        end
    end

    always_comb begin
        {port_d_pullup_o, port_c_pullup_o, port_b_pullup_o} = pullup_ff;
        {port_d_oe_n_o, port_c_oe_n_o, port_b_oe_n_o}       = oe_n_ff;
        {port_d_value_o, port_c_value_o, port_b_value_o}    = value_ff;
        {port_d_din_en_o, port_c_din_en_o, port_b_din_en_o} = din_en_ff;
        port_c_lcd_sel_o          = c_sel_ff;
        port_c_lcd_seg_o          = c_seg_ff;
        port_d_lcd_sel_o          = d_sel_ff;
        port_d_lcd_seg_o          = d_seg_ff;
        spi_slave_select_n_o      = ss_n_ff;
        spi_master_in_o           = mi_ff;
        spi_slave_in_o            = si_ff;
        spi_sck_in_o              = sck_ff;
        pin_change_source_o       = pcs_ff;
        external_irq_zero_input_o = irq0_ff;
        timer1_capture_input_o    = icp_ff;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks; pad controls lag their causes by one clock, pin inputs by three
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    property p_ss_in_slave;
        (serial_port_enable_i && !serial_master_select_i) |=> port_b_oe_n_o[PBCD_SS_BIT];
    endproperty
    a_ss_in_slave: assert property (p_ss_in_slave) else $error("Select pin driven in slave role");

    property p_ss_select;
        (port_b_pin_i[PBCD_SS_BIT] && serial_port_enable_i && !serial_master_select_i)[*4]
            |-> spi_slave_select_n_o;
    endproperty
    a_ss_select: assert property (p_ss_select) else $error("Slave selected with pin high");

    property p_ss_master_dir;
        (serial_port_enable_i && serial_master_select_i)
            |=> port_b_oe_n_o[PBCD_SS_BIT] == !$past(port_b_dir_i[PBCD_SS_BIT]);
    endproperty
    a_ss_master_dir: assert property (p_ss_master_dir) else $error("Select direction not from its bit");

    property p_forced_pullup;
        (serial_port_enable_i && !serial_master_select_i) |=> port_b_pullup_o[PBCD_SS_BIT]
            == ($past(port_b_out_i[PBCD_SS_BIT]) && !$past(global_pullup_disable_i));
    endproperty
    a_forced_pullup: assert property (p_forced_pullup) else $error("Forced input pull-up wrong");

    property p_pin_change_source_8;
        (port_b_pin_i[PBCD_SS_BIT] && !input_sleep_disable_i)[*4] |-> pin_change_source_o[PBCD_SS_BIT];
    endproperty
    a_pin_change_source_8: assert property (p_pin_change_source_8) else $error("Pin change source 8 lost");

    property p_miso_slave;
        (serial_port_enable_i && !serial_master_select_i)
            |=> port_b_value_o[PBCD_MISO_BIT] == $past(spi_slave_out_i);
    endproperty
    a_miso_slave: assert property (p_miso_slave) else $error("Slave output not on pin");

    property p_mosi_master;
        (serial_port_enable_i && serial_master_select_i)
            |=> port_b_value_o[PBCD_MOSI_BIT] == $past(spi_master_out_i);
    endproperty
    a_mosi_master: assert property (p_mosi_master) else $error("Master output not on pin");

    property p_seg_c;
        1'b1 |=> port_c_lcd_seg_o[7] == $past(lcd_front_plane_5_to_12_i[0])
             && port_c_lcd_seg_o[0] == $past(lcd_front_plane_5_to_12_i[7]);
    endproperty
    a_seg_c: assert property (p_seg_c) else $error("Port C segment order wrong");

    property p_seg_d;
        1'b1 |=> port_d_lcd_seg_o[7] == $past(lcd_front_plane_15_to_20_i[0])
             && port_d_lcd_seg_o[2] == $past(lcd_front_plane_15_to_20_i[5]);
    endproperty
    a_seg_d: assert property (p_seg_d) else $error("Port D segment order wrong");

    property p_irq0;
        (port_d_pin_i[PBCD_D_IRQ_BIT] && external_irq_zero_enable_i && !lcd_controller_enable_i)[*4]
            |-> external_irq_zero_input_o;
    endproperty
    a_irq0: assert property (p_irq0) else $error("Interrupt 0 input lost");

    property p_icp;
        (port_d_pin_i[PBCD_D_ICP_BIT] && !input_sleep_disable_i && !lcd_controller_enable_i)[*4]
            |-> timer1_capture_input_o;
    endproperty
    a_icp: assert property (p_icp) else $error("Capture input lost");

    property p_compare;
        timer_compare_enable_i[0] |=> port_b_value_o[PBCD_CMP_LO] == $past(timer_compare_value_i[0]);
    endproperty
    a_compare: assert property (p_compare) else $error("Compare output not on pin");

    property p_lcd_c;
        lcd_controller_enable_i |=> port_c_pullup_o == PBCD_RST_ZERO && port_c_oe_n_o == PBCD_RST_OE_N
            && port_c_din_en_o == PBCD_RST_ZERO && port_c_lcd_sel_o == PBCD_RST_OE_N;
    endproperty
    a_lcd_c: assert property (p_lcd_c) else $error("Port C not released to display");

    property p_pud;
        global_pullup_disable_i |=> port_b_pullup_o == PBCD_RST_ZERO
            && port_c_pullup_o == PBCD_RST_ZERO && port_d_pullup_o == PBCD_RST_ZERO;
    endproperty
    a_pud: assert property (p_pud) else $error("Pull-up on while disabled");

    property p_miso_master;
        (serial_port_enable_i && serial_master_select_i) |=> port_b_oe_n_o[PBCD_MISO_BIT];
    endproperty
    a_miso_master: assert property (p_miso_master) else $error("MISO driven in master role");

    property p_sck_slave;
        (serial_port_enable_i && !serial_master_select_i) |=> port_b_oe_n_o[PBCD_SCK_BIT];
    endproperty
    a_sck_slave: assert property (p_sck_slave) else $error("Clock pin driven in slave role");

    c_slave_sel: cover property (serial_port_enable_i && !serial_master_select_i && !spi_slave_select_n_o);
    c_master: cover property (serial_port_enable_i && serial_master_select_i ##1 spi_master_in_o);
    c_lcd_d: cover property (lcd_controller_enable_i && lcd_pin_mask_i > PBCD_PM_GT10 ##1 port_d_lcd_sel_o[0]);
endmodule // pbcd_port_mux

// File: pbcd_pad_model.sv
// Pad and far-side driver model for one 8-bit port
`timescale 1ns/10ps
module pbcd_pad_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] oe_n_i,
    input  wire logic [7:0] value_i,
    input  wire logic [7:0] pullup_i,
    input  wire logic [7:0] ext_en_i,
    input  wire logic [7:0] ext_val_i,
    output logic [7:0]      pin_o
);
    // A floating pad does not keep its last level, so the model flips it each cycle
    logic [7:0] float_ff = 8'h55;
    always_ff @(posedge clk_i) begin
        float_ff <= ~pin_o;
    end
    always_comb begin
        for (int k = 0; k < 8; k++) begin
            if (!oe_n_i[k]) begin
                pin_o[k] = value_i[k];
            end else if (ext_en_i[k]) begin
                pin_o[k] = ext_val_i[k];
            end else begin
                pin_o[k] = pullup_i[k] ? 1'b1 : float_ff[k];
            end
        end
    end
endmodule // pbcd_pad_model

// File: pbcd_port_mux_tb_top.sv
// Self-checking bench for the port B/C/D alternate-function pad block
`timescale 1ns/10ps
module pbcd_port_mux_tb_top;
    logic       clk_i = 1'b0;
    logic       reset_n_i = 1'b0;
    logic [7:0] port_b_dir_i, port_b_out_i, port_c_dir_i, port_c_out_i, port_d_dir_i, port_d_out_i;
    logic [7:0] port_b_pin_i, port_c_pin_i, port_d_pin_i, pin_change_mask_i, lcd_front_plane_5_to_12_i;
    logic       global_pullup_disable_i, input_sleep_disable_i, serial_port_enable_i, serial_master_select_i;
    logic       spi_master_out_i, spi_slave_out_i, spi_sck_out_i, pin_change_group1_enable_i;
    logic       lcd_controller_enable_i, lcd_front_plane_21_i, lcd_front_plane_22_i, external_irq_zero_enable_i;
    logic [3:0] timer_compare_enable_i, timer_compare_value_i;
    logic [2:0] lcd_pin_mask_i;
    logic [5:0] lcd_front_plane_15_to_20_i;
    logic [7:0] port_b_pullup_o, port_b_oe_n_o, port_b_value_o, port_b_din_en_o, port_c_pullup_o, port_c_oe_n_o;
    logic [7:0] port_c_value_o, port_c_din_en_o, port_d_pullup_o, port_d_oe_n_o, port_d_value_o, port_d_din_en_o;
    logic [7:0] port_c_lcd_sel_o, port_c_lcd_seg_o, port_d_lcd_sel_o, port_d_lcd_seg_o, pin_change_source_o;
    logic       spi_slave_select_n_o, spi_master_in_o, spi_slave_in_o, spi_sck_in_o;
    logic       external_irq_zero_input_o, timer1_capture_input_o;
    logic [7:0] b_ext, c_ext, d_ext;
    int         mismatches = 0;
    int         comparisons = 0;
    int         cycles = 0;
    ////////////////////////////////////////////////////////////////////////////////
    pbcd_port_mux DUT (.clk_i, .reset_n_i, .port_b_dir_i, .port_b_out_i, .port_c_dir_i, .port_c_out_i,
        .port_d_dir_i, .port_d_out_i, .port_b_pin_i, .port_c_pin_i, .port_d_pin_i, .global_pullup_disable_i,
        .input_sleep_disable_i, .serial_port_enable_i, .serial_master_select_i, .spi_master_out_i,
        .spi_slave_out_i, .spi_sck_out_i, .timer_compare_enable_i, .timer_compare_value_i,
        .pin_change_group1_enable_i, .pin_change_mask_i, .lcd_controller_enable_i, .lcd_pin_mask_i,
        .lcd_front_plane_5_to_12_i, .lcd_front_plane_15_to_20_i, .lcd_front_plane_21_i, .lcd_front_plane_22_i,
        .external_irq_zero_enable_i, .port_b_pullup_o, .port_b_oe_n_o, .port_b_value_o, .port_b_din_en_o,
        .port_c_pullup_o, .port_c_oe_n_o, .port_c_value_o, .port_c_din_en_o, .port_d_pullup_o, .port_d_oe_n_o,
        .port_d_value_o, .port_d_din_en_o, .port_c_lcd_sel_o, .port_c_lcd_seg_o, .port_d_lcd_sel_o,
        .port_d_lcd_seg_o, .spi_slave_select_n_o, .spi_master_in_o, .spi_slave_in_o, .spi_sck_in_o,
        .pin_change_source_o, .external_irq_zero_input_o, .timer1_capture_input_o);
    pbcd_pad_model pad_b (.clk_i, .oe_n_i(port_b_oe_n_o), .value_i(port_b_value_o), .pullup_i(port_b_pullup_o),
        .ext_en_i(8'hff), .ext_val_i(b_ext), .pin_o(port_b_pin_i));
    pbcd_pad_model pad_c (.clk_i, .oe_n_i(port_c_oe_n_o), .value_i(port_c_value_o), .pullup_i(port_c_pullup_o),
        .ext_en_i(8'hff), .ext_val_i(c_ext), .pin_o(port_c_pin_i));
    pbcd_pad_model pad_d (.clk_i, .oe_n_i(port_d_oe_n_o), .value_i(port_d_value_o), .pullup_i(port_d_pullup_o),
        .ext_en_i(8'hff), .ext_val_i(d_ext), .pin_o(port_d_pin_i));
    ////////////////////////////////////////////////////////////////////////////////
    always #25 clk_i = ~clk_i;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t ns: %s saw %h expected %h", $time, what, seen, exp);
        end
    endtask
    // One edge for the pad controls, three more for a pad level to come back through the synchroniser
    task automatic settle;
        repeat (4) @(posedge clk_i);
        #1;
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 1000) begin
            mismatches++;
            $display("wrong value at %0t ns: run did not finish", $time);
            results();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {port_b_dir_i, port_b_out_i, port_c_dir_i, port_c_out_i, port_d_dir_i, port_d_out_i} = '0;
        {global_pullup_disable_i, input_sleep_disable_i, serial_port_enable_i, serial_master_select_i} = '0;
        {spi_master_out_i, spi_slave_out_i, spi_sck_out_i, pin_change_group1_enable_i, pin_change_mask_i} = '0;
        {lcd_controller_enable_i, lcd_pin_mask_i, lcd_front_plane_5_to_12_i, lcd_front_plane_15_to_20_i} = '0;
        {lcd_front_plane_21_i, lcd_front_plane_22_i, external_irq_zero_enable_i} = '0;
        {timer_compare_enable_i, timer_compare_value_i, b_ext, c_ext, d_ext} = '0;
        repeat (2) @(posedge clk_i);
        #1;
        check(port_b_oe_n_o, 8'hff, "reset oe_n");
        check(spi_slave_select_n_o, 1'b1, "reset select");
        reset_n_i = 1'b1;
        $display("test reset finished");
        {serial_port_enable_i, port_b_dir_i, port_b_out_i, spi_slave_out_i, b_ext} = {1'b1, 16'hff0f, 1'b1, 8'h06};
        settle();
        check(port_b_oe_n_o, 8'h07, "slave oe_n");
        check(port_b_pullup_o, 8'h07, "slave pull-up");
        check(port_b_value_o, 8'h0f, "slave value");
        check(spi_slave_in_o, 1'b1, "slave data in");
        check(spi_sck_in_o, 1'b1, "slave clock in");
        check(spi_slave_select_n_o, 1'b0, "select low");
        {spi_slave_out_i, b_ext} = {1'b0, 8'h07};
        settle();
        check(spi_slave_select_n_o, 1'b1, "select high");
        check(port_b_value_o, 8'h07, "slave value");
        check(pin_change_source_o, 8'h07, "pin change");
        $display("test slave finished");
        {serial_master_select_i, spi_master_out_i, b_ext} = {1'b1, 1'b1, 8'h08};
        settle();
        check(port_b_oe_n_o, 8'h08, "master oe_n");
        check(port_b_pullup_o, 8'h08, "master pull-up");
        check(port_b_value_o, 8'h0d, "master value");
        check(spi_master_in_o, 1'b1, "master data in");
        check(spi_slave_select_n_o, 1'b1, "master unselected");
        $display("test master finished");
        for (int p = 0; p < 2; p++) begin
            {global_pullup_disable_i, port_b_dir_i, port_b_out_i, port_c_out_i, port_d_out_i} = {p[0], 32'h00ffffff};
            settle();
            check(port_b_pullup_o, p ? 8'h00 : 8'hff, "b pull-up");
            check(port_c_pullup_o, p ? 8'h00 : 8'hff, "c pull-up");
            check(port_d_pullup_o, p ? 8'h00 : 8'hff, "d pull-up");
        end
        $display("test pull-up finished");
        {serial_port_enable_i, global_pullup_disable_i} = 2'b00;
        for (int r = 0; r < 2; r++) begin
            {port_b_dir_i, port_b_out_i} = {8'hff, r ? 8'hf0 : 8'h00};
            {timer_compare_enable_i, timer_compare_value_i} = {4'ha, r ? 4'h0 : 4'hf};
            settle();
            check(port_b_value_o, r ? 8'h50 : 8'ha0, "compare value");
        end
        $display("test compare finished");
        {lcd_controller_enable_i, lcd_pin_mask_i, port_c_dir_i, port_d_dir_i} = {1'b1, 3'h5, 16'hffff};
        settle();
        check(port_c_pullup_o, 8'h00, "c pull-up");
        check(port_c_oe_n_o, 8'hff, "c oe_n");
        check(port_c_din_en_o, 8'h00, "c input enable");
        check(port_c_lcd_sel_o, 8'hff, "c to lcd");
        check(port_d_oe_n_o, 8'hff, "d oe_n");
        lcd_pin_mask_i = 3'h2;
        settle();
        check(port_d_oe_n_o, 8'hc0, "d oe_n partial");
        check(port_d_din_en_o, 8'h3d, "d input enable");
        check(port_d_lcd_sel_o, 8'hc0, "d to lcd");
        for (int k = 0; k < 8; k++) begin
            {lcd_front_plane_5_to_12_i, lcd_front_plane_15_to_20_i} = {8'h01 << k, 6'h01 << (k % 6)};
            settle();
            check(port_c_lcd_seg_o, 8'h80 >> k, "c segment");
            check(port_d_lcd_seg_o, 8'h80 >> (k % 6), "d segment");
        end
        for (int j = 0; j < 2; j++) begin
            {lcd_front_plane_15_to_20_i, lcd_front_plane_21_i, lcd_front_plane_22_i} = {6'h00, j ? 2'b01 : 2'b10};
            settle();
            check(port_d_lcd_seg_o, j ? 8'h01 : 8'h02, "d low segment");
        end
        $display("test lcd finished");
        {lcd_controller_enable_i, port_d_dir_i, d_ext, external_irq_zero_enable_i} = {1'b0, 16'h0003, 1'b1};
        settle();
        check(external_irq_zero_input_o, 1'b1, "irq input");
        check(timer1_capture_input_o, 1'b1, "capture input");
        {input_sleep_disable_i, pin_change_group1_enable_i, pin_change_mask_i, b_ext} = {2'b11, 16'h01ff};
        port_b_dir_i = 8'h00;
        settle();
        check(external_irq_zero_input_o, 1'b1, "irq kept");
        check(timer1_capture_input_o, 1'b0, "capture gated");
        check(pin_change_source_o, 8'h01, "pin change 8");
        check(port_b_din_en_o, 8'h01, "b input enable");
        external_irq_zero_enable_i = 1'b0;
        settle();
        check(external_irq_zero_input_o, 1'b0, "irq gated");
        $display("test inputs finished");
        results();
    end
endmodule // pbcd_port_mux_tb_top
